// File: dac_pkg.sv
// Constants, offsets, encodings and timing for the DAC update controller.
// Assumes a single 10 MHz system clock; all counts derive from it.
package dac_pkg;
	// Register byte offsets on the plain register port
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_CLEAR = 8'h08;
	localparam logic [7:0] OFF_ENABLE = 8'h0C;
	localparam logic [7:0] OFF_FIFO = 8'h10;
	localparam logic [7:0] OFF_THRESH = 8'h14;
	localparam logic [7:0] OFF_LEVEL = 8'h18;
	localparam logic [7:0] OFF_PERIOD = 8'h1C;
	localparam logic [7:0] OFF_CAL_ADDR = 8'h20;
	localparam logic [7:0] OFF_CAL_DATA = 8'h24;
	localparam logic [7:0] OFF_HOLD0 = 8'h40;
	// Control fields
	localparam int CTRL_SWRST_BIT = 0;
	localparam int CTRL_TSEL_LO = 2;
	// FIFO word layout
	localparam int FLAG_BIT = 19;
	localparam int SAMPLE_W = 16;
	localparam int ENTRY_W = 20;
	// Status bit positions
	localparam int ST_BELOW = 0;
	localparam int ST_DONE = 1;
	localparam int ST_OVF = 2;
	localparam int ST_W = 3;
	// Values after reset
	localparam logic [1:0] RST_TSEL = 2'h3;
	localparam logic [15:0] RST_THRESH = 16'h0000;
	localparam logic [23:0] RST_PERIOD = 24'h0000FF;
	localparam logic [ST_W-1:0] RST_ENABLE = 3'h0;
	// Sequencing
	localparam logic [5:0] SHIFT_START = 6'h20;
	localparam int CHIP_BITS = 64;
	localparam logic [23:0] MIN_PERIOD = 24'h0000C0;
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int TRIG_OUT_NS = 500;
	localparam int TRIG_OUT_CYC_I = (TRIG_OUT_NS / CLK_PERIOD_NS < 1) ? 1 :
		TRIG_OUT_NS / CLK_PERIOD_NS;
	localparam logic [3:0] TRIG_OUT_CYC = 4'(TRIG_OUT_CYC_I);
	// Trigger select encodings
	typedef enum logic [1:0] {
		TSEL_TIMER = 2'b00,
		TSEL_EXT_IN = 2'b01,
		TSEL_TIMER_OUT = 2'b10,
		TSEL_OFF = 2'b11
	} tsel_t;
	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_LOAD = 4'b0010,
		S_WAIT = 4'b0100,
		S_SHIFT = 4'b1000
	} seq_t;
endpackage

// File: dac_update_trigger_control.sv
// DAC update controller: output FIFO, eight holding registers, triggers,
// serial feed to two quad DACs, threshold interrupt, calibration store.
// Assumes a register master on CLOCK and an asynchronous trigger pin.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Channels that get no new sample in a refresh keep their held value.
// - A FIFO entry with bit 19 set ends the refresh, allowing a subset.
// - All holding registers clear on power-up and on software reset.
// - With external input selected, a falling trigger edge updates all eight.
// - In external input mode all falling edges before a refresh starts give one update.
// - In trigger-output mode a low pulse of about 500 ns marks each trigger.
// - Trigger input is digital channel 1, trigger output digital channel 9.
// - An interrupt is requested while the FIFO holds fewer than threshold.
// - That interrupt is a level that drops when either condition ends.
// - Software reads and writes offset and gain coefficients per channel.
// - Internal triggers come from a 24-bit programmable period counter.
// - Samples are loaded by phase 20hex, then shifting to the DACs starts.
// - Channels 0-3 go to the first DAC chip, channels 4-7 to the second.
module dac_update_trigger_control #(
	parameter int FIFO_DEPTH = 1024
) (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic IRQ,
	input wire logic DIO1_IN,
	output logic DIO9_OUT,
	output logic DIO9_OE,
	output logic DAC_SCLK,
	output logic DAC_SDI0,
	output logic DAC_SDI1,
	output logic DAC_SYNC_B,
	output logic DAC_LDAC_B
);
	localparam int AW = $clog2(FIFO_DEPTH);

	// Depth must be a power of two for wrapping pointers
	// Count must fit below the flags at bit 16 of the level word
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 32768 ||
		(1 << AW) != FIFO_DEPTH) begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two from 2 to 32768");
	end

	// Register address match, used by every decode except the holding register window
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// Holding register window decode
	function automatic logic hold_hit(input logic [7:0] a);
		return a[7:5] == dac_pkg::OFF_HOLD0[7:5] && a[1:0] == 2'h0;
	endfunction

	logic rst;
	logic [1:0] tsel_r, tsel_nxt;
	logic srst_r, srst_nxt;
	logic [15:0] thresh_r, thresh_nxt;
	logic [23:0] period_r, period_nxt;
	logic [dac_pkg::ST_W-1:0] sticky_r, sticky_nxt, enable_r, enable_nxt;
	logic [3:0] cal_addr_r, cal_addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic [dac_pkg::SAMPLE_W-1:0] cal_mem [16];
	logic [dac_pkg::ENTRY_W-1:0] fifo_mem [FIFO_DEPTH];
	logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop, full, empty, below;
	logic [dac_pkg::ENTRY_W-1:0] head;
	logic [dac_pkg::ST_W-1:0] status;
	logic sync1_r, sync2_r, sync3_r, fall;
	logic [23:0] tmr_r, tmr_nxt;
	logic tick, pend_r, pend_nxt, start;
	logic [3:0] tout_r, tout_nxt;
	logic oe_r, oe_nxt, tout_pin_r, tout_pin_nxt;
	dac_pkg::seq_t state_r, state_nxt;
	logic [5:0] phase_r, phase_nxt;
	logic [2:0] ch_r, ch_nxt;
	logic [dac_pkg::SAMPLE_W-1:0] hold_r [8];
	logic [dac_pkg::SAMPLE_W-1:0] hold_nxt [8];
	logic [dac_pkg::CHIP_BITS-1:0] sh0_r, sh0_nxt, sh1_r, sh1_nxt;
	logic [5:0] bit_r, bit_nxt;
	logic sclk_r, sclk_nxt, sync_b_r, sync_b_nxt, ldac_b_r, ldac_b_nxt;
	logic done_ev;

	// Power-up reset or software reset pulse
	assign rst = !RST_B || srst_r;

	// FIFO flags and head entry
	assign full = cnt_r[AW];
	assign empty = cnt_r == '0;
	assign head = fifo_mem[rptr_r];
	assign push = WR && hit(ADDR, dac_pkg::OFF_FIFO) && !full;
	assign below = {{(16 - AW - 1){1'b0}}, cnt_r} < thresh_r;

	// Live below-threshold level plus sticky events
	always_comb begin
		status = sticky_r;
		status[dac_pkg::ST_BELOW] = below;
	end

	// Trigger input edge: third stage holds history of the second
	assign fall = sync3_r && !sync2_r;
	assign start = pend_r && state_r == dac_pkg::S_IDLE;

	// Register file next values and read mux
	always_comb begin
		tsel_nxt = tsel_r;
		srst_nxt = 1'b0;
		thresh_nxt = thresh_r;
		period_nxt = period_r;
		enable_nxt = enable_r;
		cal_addr_nxt = cal_addr_r;
		sticky_nxt = sticky_r;
		rdata_nxt = 32'h00000000;
		if (WR && hit(ADDR, dac_pkg::OFF_CTRL)) begin
			tsel_nxt = WDATA[dac_pkg::CTRL_TSEL_LO +: 2];
			srst_nxt = WDATA[dac_pkg::CTRL_SWRST_BIT];
		end
		if (WR && hit(ADDR, dac_pkg::OFF_THRESH)) begin
			thresh_nxt = WDATA[15:0];
		end
		if (WR && hit(ADDR, dac_pkg::OFF_PERIOD)) begin
			period_nxt = WDATA[23:0];
		end
		if (WR && hit(ADDR, dac_pkg::OFF_ENABLE)) begin
			enable_nxt = WDATA[dac_pkg::ST_W-1:0];
		end
		if (WR && hit(ADDR, dac_pkg::OFF_CAL_ADDR)) begin
			cal_addr_nxt = WDATA[3:0];
		end
		// Clear first, then set, so a same-cycle event survives
		if (WR && hit(ADDR, dac_pkg::OFF_CLEAR)) begin
			sticky_nxt = sticky_r & ~WDATA[dac_pkg::ST_W-1:0];
		end
		if (done_ev) begin
			sticky_nxt[dac_pkg::ST_DONE] = 1'b1;
		end
		if (WR && hit(ADDR, dac_pkg::OFF_FIFO) && full) begin
			sticky_nxt[dac_pkg::ST_OVF] = 1'b1;
		end
		sticky_nxt[dac_pkg::ST_BELOW] = 1'b0;
		if (RD) begin
			if (hit(ADDR, dac_pkg::OFF_CTRL)) begin
				rdata_nxt[dac_pkg::CTRL_TSEL_LO +: 2] = tsel_r;
			end else if (hit(ADDR, dac_pkg::OFF_STATUS)) begin
				rdata_nxt[dac_pkg::ST_W-1:0] = status;
			end else if (hit(ADDR, dac_pkg::OFF_ENABLE)) begin
				rdata_nxt[dac_pkg::ST_W-1:0] = enable_r;
			end else if (hit(ADDR, dac_pkg::OFF_THRESH)) begin
				rdata_nxt[15:0] = thresh_r;
			end else if (hit(ADDR, dac_pkg::OFF_LEVEL)) begin
				rdata_nxt[AW:0] = cnt_r;
				rdata_nxt[16] = full;
				rdata_nxt[17] = empty;
				rdata_nxt[18] = below;
			end else if (hit(ADDR, dac_pkg::OFF_PERIOD)) begin
				rdata_nxt[23:0] = period_r;
			end else if (hit(ADDR, dac_pkg::OFF_CAL_ADDR)) begin
				rdata_nxt[3:0] = cal_addr_r;
			end else if (hit(ADDR, dac_pkg::OFF_CAL_DATA)) begin
				rdata_nxt[15:0] = cal_mem[cal_addr_r];
			end else if (hold_hit(ADDR)) begin
				rdata_nxt[15:0] = hold_r[ADDR[4:2]];
			end
		end
		irq_nxt = |(status & enable_r);
	end

	// Trigger sources, pending start and trigger-out pulse
	always_comb begin
		tmr_nxt = tmr_r;
		tick = 1'b0;
		if (tsel_r == dac_pkg::TSEL_TIMER || tsel_r == dac_pkg::TSEL_TIMER_OUT) begin
			if (tmr_r == 24'h000000) begin
				tick = 1'b1;
				tmr_nxt = (period_r < dac_pkg::MIN_PERIOD) ?
					dac_pkg::MIN_PERIOD : period_r;
			end else begin
				tmr_nxt = tmr_r - 24'h000001;
			end
		end else begin
			tmr_nxt = period_r;
		end
		pend_nxt = pend_r;
		if (start) begin
			pend_nxt = 1'b0;
		end
		// One pending start for any number of falling edges; merges the edges
		if (tick || (fall && tsel_r == dac_pkg::TSEL_EXT_IN)) begin
			pend_nxt = 1'b1;
		end
		oe_nxt = tsel_r == dac_pkg::TSEL_TIMER_OUT;
		tout_nxt = tout_r;
		if (start && oe_nxt) begin
			tout_nxt = dac_pkg::TRIG_OUT_CYC;
		end else if (tout_r != 4'h0) begin
			tout_nxt = tout_r - 4'h1;
		end
		// Pin only pulled low while driven, even on a mode change
		tout_pin_nxt = !(oe_nxt && tout_nxt != 4'h0);
	end

	// FIFO pointers and fill count
	always_comb begin
		wptr_nxt = push ? wptr_r + AW'(1) : wptr_r;
		rptr_nxt = pop ? rptr_r + AW'(1) : rptr_r;
		cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	// Refresh sequencer: load holding registers, then shift out
	always_comb begin
		state_nxt = state_r;
		phase_nxt = phase_r;
		ch_nxt = ch_r;
		hold_nxt = hold_r;
		sh0_nxt = sh0_r;
		sh1_nxt = sh1_r;
		bit_nxt = bit_r;
		sclk_nxt = sclk_r;
		sync_b_nxt = sync_b_r;
		ldac_b_nxt = 1'b1;
		pop = 1'b0;
		done_ev = 1'b0;
		case (state_r)
			dac_pkg::S_IDLE: begin
				if (start) begin
					state_nxt = dac_pkg::S_LOAD;
					phase_nxt = 6'h00;
					ch_nxt = 3'h0;
				end
			end
			dac_pkg::S_LOAD: begin
				phase_nxt = phase_r + 6'h01;
				if (empty) begin
					state_nxt = dac_pkg::S_WAIT;
				end else begin
					pop = 1'b1;
					hold_nxt[ch_r] = head[dac_pkg::SAMPLE_W-1:0];
					if (head[dac_pkg::FLAG_BIT] || ch_r == 3'h7) begin
						state_nxt = dac_pkg::S_WAIT;
					end else begin
						ch_nxt = ch_r + 3'h1;
					end
				end
			end
			dac_pkg::S_WAIT: begin
				phase_nxt = phase_r + 6'h01;
				if (phase_r == dac_pkg::SHIFT_START - 6'h01) begin
					state_nxt = dac_pkg::S_SHIFT;
					sh0_nxt = {hold_r[0], hold_r[1], hold_r[2], hold_r[3]};
					sh1_nxt = {hold_r[4], hold_r[5], hold_r[6], hold_r[7]};
					bit_nxt = 6'h00;
					sclk_nxt = 1'b0;
					sync_b_nxt = 1'b0;
				end
			end
			dac_pkg::S_SHIFT: begin
				if (!sclk_r) begin
					sclk_nxt = 1'b1;
				end else begin
					sclk_nxt = 1'b0;
					sh0_nxt = {sh0_r[dac_pkg::CHIP_BITS-2:0], 1'b0};
					sh1_nxt = {sh1_r[dac_pkg::CHIP_BITS-2:0], 1'b0};
					bit_nxt = bit_r + 6'h01;
					if (bit_r == 6'h3F) begin
						sync_b_nxt = 1'b1;
						ldac_b_nxt = 1'b0;
						done_ev = 1'b1;
						state_nxt = dac_pkg::S_IDLE;
					end
				end
			end
			default: begin
				state_nxt = dac_pkg::S_IDLE;
			end
		endcase
	end

	// Calibration store and FIFO array; contents survive reset
	always_ff @(posedge CLOCK) begin
		if (WR && hit(ADDR, dac_pkg::OFF_CAL_DATA)) begin
			cal_mem[cal_addr_r] <= WDATA[dac_pkg::SAMPLE_W-1:0];
		end
		if (push) begin
			fifo_mem[wptr_r] <= WDATA[dac_pkg::ENTRY_W-1:0];
		end
	end

	// Trigger pin synchroniser, not cleared by software reset
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			sync3_r <= 1'b1;
			srst_r <= 1'b0;
		end else begin
			sync1_r <= DIO1_IN;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			srst_r <= srst_nxt;
		end
	end

	// Registered state
	always_ff @(posedge CLOCK) begin
		if (rst) begin
			tsel_r <= dac_pkg::RST_TSEL;
			thresh_r <= dac_pkg::RST_THRESH;
			period_r <= dac_pkg::RST_PERIOD;
			enable_r <= dac_pkg::RST_ENABLE;
			sticky_r <= '0;
			cal_addr_r <= 4'h0;
			rdata_r <= 32'h00000000;
			irq_r <= 1'b0;
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
			tmr_r <= dac_pkg::RST_PERIOD;
			pend_r <= 1'b0;
			tout_r <= 4'h0;
			oe_r <= 1'b0;
			tout_pin_r <= 1'b1;
			state_r <= dac_pkg::S_IDLE;
			phase_r <= 6'h00;
			ch_r <= 3'h0;
			for (int i = 0; i < 8; i++) begin
				hold_r[i] <= '0;
			end
			sh0_r <= '0;
			sh1_r <= '0;
			bit_r <= 6'h00;
			sclk_r <= 1'b0;
			sync_b_r <= 1'b1;
			ldac_b_r <= 1'b1;
		end else begin
			tsel_r <= tsel_nxt;
			thresh_r <= thresh_nxt;
			period_r <= period_nxt;
			enable_r <= enable_nxt;
			sticky_r <= sticky_nxt;
			cal_addr_r <= cal_addr_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r <= cnt_nxt;
			tmr_r <= tmr_nxt;
			pend_r <= pend_nxt;
			tout_r <= tout_nxt;
			oe_r <= oe_nxt;
			tout_pin_r <= tout_pin_nxt;
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			ch_r <= ch_nxt;
			hold_r <= hold_nxt;
			sh0_r <= sh0_nxt;
			sh1_r <= sh1_nxt;
			bit_r <= bit_nxt;
			sclk_r <= sclk_nxt;
			sync_b_r <= sync_b_nxt;
			ldac_b_r <= ldac_b_nxt;
		end
	end

	// Outputs straight from flops
	assign RDATA = rdata_r;
	assign IRQ = irq_r;
	assign DIO9_OUT = tout_pin_r;
	assign DIO9_OE = oe_r;
	assign DAC_SCLK = sclk_r;
	assign DAC_SDI0 = sh0_r[dac_pkg::CHIP_BITS-1];
	assign DAC_SDI1 = sh1_r[dac_pkg::CHIP_BITS-1];
	assign DAC_SYNC_B = sync_b_r;
	assign DAC_LDAC_B = ldac_b_r;
endmodule

`default_nettype wire

// File: dac_upd_monitor.sv
// Port checker for the DAC update controller.
// Assumes it is bound onto the top module, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dac_upd_monitor (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic IRQ,
	input wire logic DIO9_OUT,
	input wire logic DIO9_OE,
	input wire logic DAC_SCLK,
	input wire logic DAC_SYNC_B,
	input wire logic DAC_LDAC_B
);
	logic [7:0] bits_r;
	logic sclk_q_r;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_B);
	// Rising serial clocks counted inside a frame
	always_ff @(posedge CLOCK) begin
		sclk_q_r <= DAC_SCLK;
		if (!RST_B || DAC_SYNC_B) begin
			bits_r <= 8'h00;
		end else if (DAC_SCLK && !sclk_q_r) begin
			bits_r <= bits_r + 8'h01;
		end
	end
	chk_sclk_idle: assert property (DAC_SYNC_B |-> !DAC_SCLK)
		else $error("serial clock moves outside a frame");
	chk_frame_bits: assert property ($rose(DAC_SYNC_B) |-> bits_r == 8'h40)
		else $error("frame length is not 64 bits");
	chk_load_after: assert property ($rose(DAC_SYNC_B) |-> ##[0:1] !DAC_LDAC_B)
		else $error("no load pulse after frame");
	chk_load_pulse: assert property (!DAC_LDAC_B |-> DAC_SYNC_B ##1 DAC_LDAC_B)
		else $error("load pulse malformed");
	chk_trig_width: assert property ($fell(DIO9_OUT) |->
		!DIO9_OUT [*5] ##1 DIO9_OUT)
		else $error("trigger output pulse not 5 cycles");
	chk_trig_oe: assert property (!DIO9_OUT |-> DIO9_OE)
		else $error("trigger driven low without enable");
	chk_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
		else $error("read data outside read slot");
	chk_reset_quiet: assert property (!$past(RST_B) |-> !IRQ && DAC_SYNC_B
		&& DAC_LDAC_B && !DIO9_OE)
		else $error("outputs not quiet after reset");
endmodule
bind dac_update_trigger_control dac_upd_monitor u_mon (
	.CLOCK(CLOCK),
	.RST_B(RST_B),
	.RD(RD),
	.RDATA(RDATA),
	.IRQ(IRQ),
	.DIO9_OUT(DIO9_OUT),
	.DIO9_OE(DIO9_OE),
	.DAC_SCLK(DAC_SCLK),
	.DAC_SYNC_B(DAC_SYNC_B),
	.DAC_LDAC_B(DAC_LDAC_B)
);
`default_nettype wire

// File: dac_pair_model.sv
// Model of the two serial converter chips.
// Assumes MSB-first data sampled on rising serial clock.
`timescale 1ns/1ps
`default_nettype none
module dac_pair_model (
	input wire logic sclk,
	input wire logic sdi0,
	input wire logic sdi1,
	input wire logic sync_b,
	input wire logic ldac_b,
	output logic [63:0] word0,
	output logic [63:0] word1
);
	logic [63:0] sh0 = 64'h0;
	logic [63:0] sh1 = 64'h0;
	// Shift only while the frame is open
	always @(posedge sclk) begin
		if (!sync_b) begin
			sh0 <= {sh0[62:0], sdi0};
			sh1 <= {sh1[62:0], sdi1};
		end
	end
	// Both chips load together
	always @(negedge ldac_b) begin
		word0 <= sh0;
		word1 <= sh1;
	end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the DAC update controller.
// Assumes the design package, the DAC pair model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic dio1 = 1'b1, irq, d9o, d9oe, sclk, sdi0, sdi1, sync_b, ldac_b;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [63:0] w0, w1;
	logic [15:0] hold[8], cal[16];
	logic [31:0] fq[$];
	int fails = 0, compares = 0, upd = 0, cyc = 0, t_last = 0, t_gap = 0;
	int n;
	always #50 clk = ~clk;
	// Count load pulses and the spacing between them
	always @(posedge clk) begin
		cyc++;
		if (!ldac_b) begin
			upd++;
			t_gap = cyc - t_last;
			t_last = cyc;
		end
	end
	dac_update_trigger_control #(.FIFO_DEPTH(16)) u_dut (.CLOCK(clk),
		.RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .IRQ(irq), .DIO1_IN(dio1), .DIO9_OUT(d9o),
		.DIO9_OE(d9oe), .DAC_SCLK(sclk), .DAC_SDI0(sdi0), .DAC_SDI1(sdi1),
		.DAC_SYNC_B(sync_b), .DAC_LDAC_B(ldac_b));
	dac_pair_model u_dacs (.sclk(sclk), .sdi0(sdi0), .sdi1(sdi1),
		.sync_b(sync_b), .ldac_b(ldac_b), .word0(w0), .word1(w1));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chkw(input string s, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk(s, e, rdata);
		@(posedge clk);
	endtask
	task automatic push(input logic [15:0] s, input logic last);
		d = {12'h000, last, 3'h0, s};
		wr(dac_pkg::OFF_FIFO, d);
		fq.push_back(d);
	endtask
	// Bench model of one refresh: pop until flag, eight or empty
	task automatic mref;
		for (int i = 0; i < 8; i++) begin
			if (fq.size() == 0) break;
			d = fq.pop_front();
			hold[i] = d[15:0];
			if (d[dac_pkg::FLAG_BIT]) break;
		end
	endtask
	task automatic holds;
		for (int i = 0; i < 8; i++) begin
			rdc(dac_pkg::OFF_HOLD0 + 8'(4 * i), {16'h0, hold[i]}, "hold");
		end
	endtask
	task automatic words;
		chkw("chip0", {hold[0], hold[1], hold[2], hold[3]}, w0);
		chkw("chip1", {hold[4], hold[5], hold[6], hold[7]}, w1);
	endtask
	task automatic trg;
		dio1 <= 1'b0;
		repeat (5) @(posedge clk);
		dio1 <= 1'b1;
	endtask
	task automatic wupd;
		n = upd;
		repeat (600) begin
			@(posedge clk);
			if (upd != n) break;
		end
		chk("update seen", 32'h1, 32'(upd - n));
	endtask
	task automatic irqc(input logic e);
		repeat (3) @(posedge clk);
		#1 chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge clk);
	endtask
	task automatic end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_sim();
	end
	initial begin
		void'($urandom(32'h838E29E5));
		foreach (hold[i]) hold[i] = 16'h0000;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		holds();
		// External falling edge refreshes all eight
		wr(dac_pkg::OFF_CTRL, 32'h4);
		for (int i = 0; i < 8; i++) push(16'($urandom), i == 7);
		trg();
		wupd();
		mref();
		holds();
		words();
		n = upd;
		repeat (300) @(posedge clk);
		chk("one update per edge", 32'(n), 32'(upd));
		// Partial refresh of three channels
		for (int i = 0; i < 3; i++) push(16'($urandom), i == 2);
		trg();
		wupd();
		mref();
		holds();
		words();
		// Threshold interrupt, masked and unmasked
		wr(dac_pkg::OFF_THRESH, 32'h4);
		wr(dac_pkg::OFF_ENABLE, 32'h1);
		irqc(1'b1);
		wr(dac_pkg::OFF_ENABLE, 32'h0);
		irqc(1'b0);
		wr(dac_pkg::OFF_ENABLE, 32'h1);
		for (int i = 0; i < 4; i++) push(16'($urandom), i == 3);
		irqc(1'b0);
		// Timer with trigger output, then an empty refresh
		wr(dac_pkg::OFF_PERIOD, 32'hC0);
		wr(dac_pkg::OFF_CTRL, 32'h8);
		#1 chk("trigger enable", 32'h1, {31'h0, d9oe});
		wupd();
		mref();
		wupd();
		chk("timer gap", {8'h00, dac_pkg::MIN_PERIOD} + 32'h1, 32'(t_gap));
		holds();
		words();
		irqc(1'b1);
		rdc(dac_pkg::OFF_STATUS, 32'h3, "status");
		wr(dac_pkg::OFF_CLEAR, 32'h2);
		rdc(dac_pkg::OFF_STATUS, 32'h1, "status");
		// Triggers off: an edge does nothing
		wr(dac_pkg::OFF_CTRL, 32'hC);
		repeat (250) @(posedge clk);
		n = upd;
		trg();
		repeat (300) @(posedge clk);
		chk("no update when off", 32'(n), 32'(upd));
		// Plain timer: updates run, trigger pin stays released
		for (int i = 0; i < 2; i++) push(16'($urandom), i == 1);
		wr(dac_pkg::OFF_CTRL, 32'h0);
		wupd();
		chk("trigger pin", 32'h1, {30'h0, d9oe, d9o});
		mref();
		words();
		// Overflow on a full FIFO, sticky bit and its interrupt
		wr(dac_pkg::OFF_CTRL, 32'hC);
		repeat (17) wr(dac_pkg::OFF_FIFO, 32'h0);
		wr(dac_pkg::OFF_CLEAR, 32'h2);
		rdc(dac_pkg::OFF_STATUS, 32'h4, "status");
		rdc(dac_pkg::OFF_LEVEL, 32'h00010010, "level");
		wr(dac_pkg::OFF_ENABLE, 32'h4);
		irqc(1'b1);
		wr(dac_pkg::OFF_CLEAR, 32'h4);
		irqc(1'b0);
		// Calibration store write and read back
		for (int i = 0; i < 16; i++) begin
			cal[i] = 16'($urandom);
			wr(dac_pkg::OFF_CAL_ADDR, 32'(i));
			wr(dac_pkg::OFF_CAL_DATA, {16'h0, cal[i]});
		end
		for (int i = 0; i < 16; i++) begin
			wr(dac_pkg::OFF_CAL_ADDR, 32'(i));
			rdc(dac_pkg::OFF_CAL_DATA, {16'h0, cal[i]}, "cal");
		end
		rdc(8'h3C, 32'h0, "unmapped");
		// Software reset clears the holding registers
		wr(dac_pkg::OFF_CTRL, 32'h1);
		@(posedge clk);
		foreach (hold[i]) hold[i] = 16'h0000;
		holds();
		end_sim();
	end
endmodule
`default_nettype wire
